// *** mvd_pkg.sv ***
// Package for the move and idle decode block: opcodes, field layout, AXI4-Lite map.
// Assumes one 40 MHz clock and a 32-bit AXI4-Lite register bus.
package mvd_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int INSN_W = 12;
  localparam int DATA_W = 8;
  localparam int FILE_DEPTH = 32;
  // Opcode patterns and masks
  localparam logic [11:0] COPY_MASK = 12'hFC0;
  localparam logic [11:0] COPY_PAT = 12'h200;
  localparam logic [11:0] LIT_MASK = 12'hF00;
  localparam logic [11:0] LIT_PAT = 12'hC00;
  localparam logic [11:0] STORE_MASK = 12'hFE0;
  localparam logic [11:0] STORE_PAT = 12'h020;
  localparam logic [11:0] IDLE_PAT = 12'h000;
  localparam int TGT_BIT = 5;
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_INSN = 8'h00;
  localparam logic [7:0] ADDR_ACC = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_COUNT = 8'h0C;
  localparam logic [7:0] ADDR_FILE_BASE = 8'h80;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    MVD_OP_IDLE = 3'h0,
    MVD_OP_COPY = 3'h1,
    MVD_OP_LIT = 3'h3,
    MVD_OP_STORE = 3'h2,
    MVD_OP_OTHER = 3'h6
  } mvd_op_t;

  typedef struct packed {
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
  } mvd_wreq_t;
endpackage : mvd_pkg

// *** mvd_core.sv ***
// Move and idle instruction decode and execute, with AXI4-Lite access.
// Assumes software feeds instruction words by writing the instruction register.
// Notes on behaviour
// (RL1) Words 0010 00df ffff copy a file register, index 0 to 31.
// (RL2) Copy with target bit 0 writes the value into the accumulator only.
// (RL3) Copy with target bit 1 writes the value back to the same register.
// (RL4) Copy sets the null flag when the value is zero, clears it otherwise.
// (RL5) Upper nibble 1100 loads the low eight bits into accumulator, flags kept.
// (RL6) 0000 001f ffff stores accumulator; 0000 0000 0000 idles, no change.
`timescale 1ns/100ps
`default_nettype none
module mvd_core
  import mvd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [DATA_W-1:0] file_mem [FILE_DEPTH];
  logic [DATA_W-1:0] acc;
  logic null_flag;
  logic [15:0] exec_count;
  logic [INSN_W-1:0] last_insn;
  logic aw_held, w_held;
  mvd_wreq_t wreq;
  logic exec_go;
  logic file_we;
  logic [4:0] file_idx;
  logic [DATA_W-1:0] file_wval;
  mvd_op_t op;
  logic [INSN_W-1:0] insn;

  // Write channel capture; address and data may arrive in either order
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wreq <= '0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        wreq.awaddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        wreq.wdata <= s_axi_wdata;
        wreq.wstrb <= s_axi_wstrb;
      end
    end
  end

  logic write_fire;
  assign write_fire = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (write_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wreq.awaddr == ADDR_INSN) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // A word written to the instruction register with both low strobe bytes set executes in one cycle
  assign exec_go = write_fire && (wreq.awaddr == ADDR_INSN) && wreq.wstrb[0] && wreq.wstrb[1];
  assign insn = wreq.wdata[INSN_W-1:0];
  assign file_idx = insn[4:0];

  always_comb begin
    if ((insn & COPY_MASK) == COPY_PAT) op = MVD_OP_COPY; // [RL1]
    else if ((insn & LIT_MASK) == LIT_PAT) op = MVD_OP_LIT; // [RL5]
    else if ((insn & STORE_MASK) == STORE_PAT) op = MVD_OP_STORE; // [RL6]
    else if (insn == IDLE_PAT) op = MVD_OP_IDLE; // [RL6]
    else op = MVD_OP_OTHER;
  end

  always_comb begin
    file_we = 1'b0;
    file_wval = file_mem[file_idx];
    if (exec_go && op == MVD_OP_COPY && insn[TGT_BIT]) begin
      file_we = 1'b1; // [RL3]
    end else if (exec_go && op == MVD_OP_STORE) begin
      file_we = 1'b1; // [RL6]
      file_wval = acc;
    end
  end

  // No reset on the file array; a copy of an unwritten register reads unknown
  always_ff @(posedge ref_clk) begin
    if (file_we) file_mem[file_idx] <= file_wval;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= ACC_RESET;
    end else if (exec_go && op == MVD_OP_COPY && !insn[TGT_BIT]) begin
      acc <= file_mem[file_idx]; // [RL2]
    end else if (exec_go && op == MVD_OP_LIT) begin
      acc <= insn[7:0]; // [RL5]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      null_flag <= 1'b0;
    end else if (exec_go && op == MVD_OP_COPY) begin
      null_flag <= (file_mem[file_idx] == 8'h00); // [RL4]
    end
  end

  // Counter shows activity; unknown words are counted but do nothing
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      exec_count <= 16'h0000;
      last_insn <= 12'h000;
    end else if (exec_go) begin
      exec_count <= exec_count + 16'h0001;
      last_insn <= insn;
    end
  end

  // Read channel; file registers sit one per word from the file base
  logic [31:0] next_rdata;
  logic next_rerr;
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rerr = 1'b0;
    if (s_axi_araddr == ADDR_INSN) next_rdata = {20'h00000, last_insn};
    else if (s_axi_araddr == ADDR_ACC) next_rdata = {24'h000000, acc};
    else if (s_axi_araddr == ADDR_STATUS) next_rdata = {31'h0, null_flag};
    else if (s_axi_araddr == ADDR_COUNT) next_rdata = {16'h0000, exec_count};
    else if (s_axi_araddr[7] && s_axi_araddr[1:0] == 2'h0)
      next_rdata = {24'h000000, file_mem[s_axi_araddr[6:2]]};
    else next_rerr = 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rerr ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= s_axi_arvalid;
    end
  end

  AST_LIT_LOAD: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL5]
    exec_go && op == MVD_OP_LIT |=> acc == $past(insn[7:0]) && $stable(null_flag))
    else $error("literal load wrong");
  AST_COPY_ACC: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL2]
    exec_go && op == MVD_OP_COPY && !insn[TGT_BIT] |=> acc == file_mem[$past(file_idx)])
    else $error("copy to accumulator wrong");
  AST_COPY_BACK: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL3]
    exec_go && op == MVD_OP_COPY && insn[TGT_BIT] |=> $stable(acc))
    else $error("copy back changed accumulator");
  AST_NULL_FLAG: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL4]
    exec_go && op == MVD_OP_COPY |=> null_flag == (file_mem[$past(file_idx)] == 8'h00))
    else $error("null flag wrong");
  AST_STORE: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL6]
    exec_go && op == MVD_OP_STORE |=> file_mem[$past(file_idx)] == $past(acc) && $stable(null_flag))
    else $error("store wrong");
  AST_IDLE: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL6]
    exec_go && op == MVD_OP_IDLE |=> $stable(acc) && $stable(null_flag))
    else $error("idle changed state");
  AST_COPY_DECODE: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL1]
    insn[11:6] == 6'h08 |-> op == MVD_OP_COPY)
    else $error("copy decode wrong");
  AST_LIT_DECODE: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL5]
    insn[11:8] == 4'hC |-> op == MVD_OP_LIT)
    else $error("literal decode wrong");
  AST_STORE_DECODE: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL6]
    insn[11:5] == 7'h01 |-> op == MVD_OP_STORE)
    else $error("store decode wrong");
  AST_STORE_KEEP: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL6]
    exec_go && op == MVD_OP_STORE |=> $stable(acc))
    else $error("store changed accumulator");
  AST_BRESP_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
endmodule : mvd_core
`default_nettype wire

// *** mvd_prog_rom.sv ***
// Program memory model: sixteen 12-bit instruction words.
// Assumes the bench presents a word index and fetches a settled word.
`timescale 1ns/100ps
`default_nettype none
module mvd_prog_rom (
  input wire logic [3:0] pc,
  output logic [11:0] word
);
  // Zero value in f0 drives the null flag high
  logic [11:0] rom [16] = '{12'hC5A, 12'h03F, 12'hC00, 12'h020, 12'h23F, 12'h000,
    12'h220, 12'h260, 12'hCFF, 12'h200, 12'h000, 12'h23F, 12'hC01, 12'h021,
    12'h221, 12'h000};
  assign word = rom[pc];
endmodule : mvd_prog_rom
`default_nettype wire

// *** move_and_nop_decode_tb_top.sv ***
// Bench: runs a fixed program, then random moves, over AXI4-Lite.
// Assumes mvd_prog_rom as the program memory.
`timescale 1ns/100ps
`default_nettype none
module move_and_nop_decode_tb_top import mvd_pkg::*;;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, acc = 8'h00, v, rnd = 8'h3D;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, z = 1'b0;
  wire logic awready, wready, bvalid, arready, rvalid;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [11:0] word;
  logic [3:0] pc = 4'h0;
  logic [1:0] qb[$];
  logic [33:0] qr[$];
  logic [7:0] fr [32];
  int bad_count = 0, compares = 0, cnt = 0;
  always #12.5 ref_clk = ~ref_clk;
  mvd_prog_rom mem (.pc(pc), .word(word));
  mvd_core uut (.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic tally_and_finish;
    if (bad_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic to;
    bad_count++;
    tally_and_finish();
  endtask : to
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    qb.push_back(r);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 40);
    bready <= 1'b0;
    if (n >= 40) to();
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    qr.push_back({r, d});
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 40);
    rready <= 1'b0;
    if (n >= 40) to();
  endtask : rd
  task automatic chk_b(input logic [1:0] e, input logic [1:0] s);
    compares++;
    if (e !== s) begin
      bad_count++;
      $display("mismatch bresp exp %h got %h", e, s);
    end
  endtask : chk_b
  task automatic chk_r(input logic [33:0] e, input logic [33:0] s);
    compares++;
    if (e !== s) begin
      bad_count++;
      $display("mismatch rresp_rdata exp %h got %h", e, s);
    end
  endtask : chk_r
  // Empty queue gives x, so a stray answer never matches
  always @(posedge ref_clk) begin
    if (bvalid && bready) chk_b(qb.size() ? qb.pop_front() : 2'bxx, bresp);
    if (rvalid && rready) chk_r(qr.size() ? qr.pop_front() : 34'hx, {rresp, rdata});
  end
  task automatic ex(input logic [11:0] w);
    wr(ADDR_INSN, {20'h0, w}, RESP_OKAY);
    cnt++;
    if ((w & COPY_MASK) == COPY_PAT) begin
      v = fr[w[4:0]];
      z = (v == 8'h00);
      if (!w[TGT_BIT]) acc = v;
    end else if ((w & LIT_MASK) == LIT_PAT) acc = w[7:0];
    else if ((w & STORE_MASK) == STORE_PAT) fr[w[4:0]] = acc;
  endtask : ex
  task automatic ck(input logic [11:0] w);
    rd(ADDR_ACC, {24'h0, acc}, RESP_OKAY);
    rd(ADDR_STATUS, {31'h0, z}, RESP_OKAY);
    rd(ADDR_INSN, {20'h0, w}, RESP_OKAY);
  endtask : ck
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(ADDR_ACC, 32'h0, RESP_OKAY);
    rd(ADDR_STATUS, 32'h0, RESP_OKAY);
    rd(8'h10, 32'h0, RESP_SLVERR);
    wr(ADDR_ACC, 32'h77, RESP_SLVERR);
    for (int i = 0; i < 16; i++) begin
      pc = i[3:0];
      @(negedge ref_clk);
      ex(word);
      ck(word);
    end
    // Low strobe bytes missing: accepted but must not execute or count
    wstrb <= 4'hC;
    wr(ADDR_INSN, 32'h0000_0C33, RESP_OKAY);
    wstrb <= 4'hF;
    ck(12'h000);
    for (int i = 0; i < 32; i++) begin
      rnd = lfsr(rnd);
      ex({4'hC, rnd});
      ex({7'h01, i[4:0]});
    end
    for (int i = 0; i < 32; i++) begin
      rd(ADDR_FILE_BASE + 8'(4 * i), {24'h0, fr[i]}, RESP_OKAY);
    end
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      ex({6'h08, rnd[5:0]});
      ck({6'h08, rnd[5:0]});
    end
    rd(ADDR_COUNT, 32'(cnt), RESP_OKAY);
    tally_and_finish();
  end
endmodule : move_and_nop_decode_tb_top
`default_nettype wire
